// ### rtl/cal_store_pkg.sv
// Constants shared by the coefficient store and its word memory.
// Assumes a serial front end that delivers whole 16-bit words with an address.

package cal_store_pkg;

  // ==========================================================================
  // Word map
  localparam logic [7:0] WORD_FIRST_ADDR     = 8'h03;
  localparam logic [7:0] WORD_LAST_ADDR      = 8'h10;
  localparam int         WORD_COUNT          = 14;
  localparam logic [7:0] SIGN_WORD_A_ADDR    = 8'h03;
  localparam logic [7:0] SIGN_WORD_B_ADDR    = 8'h04;
  localparam logic [7:0] BRIDGE_OFFSET_ADDR  = 8'h05;
  localparam logic [7:0] BRIDGE_GAIN_ADDR    = 8'h06;
  localparam logic [7:0] GAIN_TEMPCO_ADDR    = 8'h07;
  localparam logic [7:0] OFFSET_TEMPCO_ADDR  = 8'h08;
  localparam logic [7:0] OFFSET_TC2_ADDR     = 8'h09;
  localparam logic [7:0] GAIN_TC2_ADDR       = 8'h0a;
  localparam logic [7:0] BRIDGE_SO_ADDR      = 8'h0b;
  localparam logic [7:0] TEMP_OFFSET_ADDR    = 8'h0c;
  localparam logic [7:0] TEMP_GAIN_ADDR      = 8'h0d;
  localparam logic [7:0] TEMP_SO_ADDR        = 8'h0e;
  localparam logic [7:0] LOW_CAL_TEMP_ADDR   = 8'h0f;
  localparam logic [7:0] MEAS_CONFIG_ADDR    = 8'h10;
  localparam logic [15:0] WORD_RESET         = 16'h0000;

  // ==========================================================================
  // Coefficient table: low word address, upper word, MSB bit, sign bit
  localparam int COEF_COUNT = 10;
  localparam logic [7:0] COEF_LOW_ADDR [COEF_COUNT] = '{
    BRIDGE_OFFSET_ADDR, BRIDGE_GAIN_ADDR, GAIN_TEMPCO_ADDR, OFFSET_TEMPCO_ADDR,
    OFFSET_TC2_ADDR, GAIN_TC2_ADDR, BRIDGE_SO_ADDR,
    TEMP_OFFSET_ADDR, TEMP_GAIN_ADDR, TEMP_SO_ADDR};
  localparam logic [7:0] COEF_HIGH_ADDR [COEF_COUNT] = '{
    SIGN_WORD_A_ADDR, SIGN_WORD_A_ADDR, SIGN_WORD_A_ADDR, SIGN_WORD_A_ADDR,
    SIGN_WORD_A_ADDR, SIGN_WORD_A_ADDR, SIGN_WORD_A_ADDR,
    SIGN_WORD_B_ADDR, SIGN_WORD_B_ADDR, SIGN_WORD_B_ADDR};
  localparam int COEF_MSB_BIT [COEF_COUNT] = '{0, 2, 4, 6, 8, 10, 12, 4, 0, 2};
  localparam int COEF_SIGN_BIT [COEF_COUNT] = '{1, 3, 5, 7, 9, 11, 13, 5, 1, 3};
  localparam int COEF_BRIDGE_OFFSET = 0;
  localparam int COEF_TEMP_OFFSET   = 7;
  localparam int COEF_MAG_WIDTH     = 17;

  // Extra bits of word 0x03
  localparam int BRIDGE_CURVE_BIT   = 14;
  localparam int LOW_CAL_SIGN_BIT   = 15;

  // ==========================================================================
  // Offset range codes: step 0x1000, largest 0x7000
  localparam int          RANGE_CODE_MSB   = 14;
  localparam int          RANGE_CODE_LSB   = 12;
  localparam logic [11:0] RANGE_FILL_ZERO  = 12'h000;
  localparam int          RANGE_TOP_BIT    = 15;
  localparam logic [3:0]  RANGE_SIXTEENTHS = 4'h8;

  // ==========================================================================
  // Measurement configuration fields and decoded values
  localparam int FIRST_GAIN_MSB  = 1;
  localparam int FIRST_GAIN_LSB  = 0;
  localparam int SECOND_GAIN_MSB = 4;
  localparam int SECOND_GAIN_LSB = 2;
  localparam int POLARITY_BIT    = 5;
  localparam int ADC_WIDTH_MSB   = 7;
  localparam int ADC_WIDTH_LSB   = 6;
  localparam logic [5:0] FIRST_GAIN_0 = 6'h0c;
  localparam logic [5:0] FIRST_GAIN_1 = 6'h14;
  localparam logic [5:0] FIRST_GAIN_2 = 6'h1e;
  localparam logic [5:0] FIRST_GAIN_3 = 6'h28;
  localparam logic [4:0] SECOND_GAIN_BASE_TENTHS = 5'h0b;
  localparam logic [4:0] ADC_BITS_0 = 5'h0a;
  localparam logic [4:0] ADC_BITS_1 = 5'h0c;
  localparam logic [4:0] ADC_BITS_2 = 5'h0e;
  localparam logic [4:0] ADC_BITS_3 = 5'h10;

endpackage

// ### rtl/cal_word_memory.sv
// Word memory of the calibration store: one 16-bit entry per mapped word.
// Assumes the owner has already decoded the address into an index.
`timescale 1ns/10ps

module cal_word_memory
  import cal_store_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_index,
  input  wire logic [15:0] wr_data,
  input  wire logic        rd_en,
  input  wire logic        rd_hit,
  input  wire logic [3:0]  rd_index,
  output logic      [15:0] rd_data_reg,
  output logic      [15:0] words_reg [WORD_COUNT]
);

  // ==========================================================================
  // Storage: every entry clears to zero; whole words only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < WORD_COUNT; i++) begin
        words_reg[i] <= WORD_RESET;
      end
    end else if (wr_en) begin
      words_reg[wr_index] <= wr_data;
    end
  end

  // Read port: registered; a same-cycle write is seen on the next read
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data_reg <= WORD_RESET;
    end else if (rd_en) begin
      rd_data_reg <= rd_hit ? words_reg[rd_index] : WORD_RESET;
    end
  end

endmodule

// ### rtl/cal_coefficient_store.sv
// Calibration coefficient store: 16-bit configuration words 0x03..0x10,
// decoded into signed coefficients and measurement settings.
// Assumes a serial front end on ref_clk that hands over whole words with
// one-cycle write and read strobes; no synchronisers are needed.
`timescale 1ns/10ps

module cal_coefficient_store (
  input  wire logic                                    ref_clk,
  input  wire logic                                    rst_n,
  input  wire logic [7:0]                              word_addr,
  input  wire logic [15:0]                             word_wdata,
  input  wire logic                                    word_wr,
  input  wire logic                                    word_rd,
  output logic      [15:0]                             word_rdata,
  output logic                                         word_rvalid_reg,
  output logic                                         write_refused_reg,
  output logic                                         config_changed_reg,
  output logic      [cal_store_pkg::COEF_MAG_WIDTH-1:0] coef_magnitude_reg [cal_store_pkg::COEF_COUNT],
  output logic                                         coef_negative_reg  [cal_store_pkg::COEF_COUNT],
  output logic      [3:0]                              bridge_range_sixteenths_reg,
  output logic      [3:0]                              temp_range_sixteenths_reg,
  output logic                                         bridge_s_curve_reg,
  output logic      [15:0]                             low_cal_raw_temperature_reg,
  output logic                                         low_cal_negative_reg,
  output logic      [5:0]                              front_amplifier_first_gain_reg,
  output logic      [4:0]                              front_amplifier_second_gain_tenths_reg,
  output logic                                         gain_inverted_reg,
  output logic      [4:0]                              coarse_adc_bits_reg
);
  import cal_store_pkg::*;

  // ==========================================================================
  // Address decode
  logic        addr_hit;
  logic [3:0]  addr_index;
  logic        offset_word;
  logic        offset_code_ok;
  logic        write_ok;
  logic [15:0] words [WORD_COUNT];

  // Only 0x03..0x10 are mapped; everything else reads zero
  assign addr_hit   = (word_addr >= WORD_FIRST_ADDR) && (word_addr <= WORD_LAST_ADDR);
  assign addr_index = 4'(word_addr - WORD_FIRST_ADDR);

  // The two offset words hold a range code, not a free number
  assign offset_word = (word_addr == BRIDGE_OFFSET_ADDR) || (word_addr == TEMP_OFFSET_ADDR);

  // A valid code is 0x0000..0x7000 in steps of 0x1000
  assign offset_code_ok = (word_wdata[RANGE_TOP_BIT] == 1'b0) &&
                          (word_wdata[RANGE_CODE_LSB-1:0] == RANGE_FILL_ZERO);

  // Refusing a bad code keeps the previous range rather than a nonsense one
  assign write_ok = word_wr && addr_hit && (!offset_word || offset_code_ok);

  // ==========================================================================
  // Word memory
  cal_word_memory u_word_memory (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .wr_en       (write_ok),
    .wr_index    (addr_index),
    .wr_data     (word_wdata),
    .rd_en       (word_rd),
    .rd_hit      (addr_hit),
    .rd_index    (addr_index),
    .rd_data_reg (word_rdata),
    .words_reg   (words)
  );

  // ==========================================================================
  // Bus answers
  // Read data follows the strobe by one cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      word_rvalid_reg <= 1'b0;
    end else begin
      word_rvalid_reg <= word_rd;
    end
  end

  // Pulse for a mapped write whose offset code was out of range
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      write_refused_reg <= 1'b0;
    end else begin
      write_refused_reg <= word_wr && addr_hit && offset_word && !offset_code_ok;
    end
  end

  // Pulse when the measurement configuration word is rewritten
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      config_changed_reg <= 1'b0;
    end else begin
      config_changed_reg <= write_ok && (word_addr == MEAS_CONFIG_ADDR);
    end
  end

  // ==========================================================================
  // Coefficient assembly
  // Decoded views lag the stored words by one cycle so every output is a flop
  for (genvar c = 0; c < COEF_COUNT; c++) begin : g_coef
    localparam int LOW_IDX  = int'(COEF_LOW_ADDR[c] - WORD_FIRST_ADDR);
    localparam int HIGH_IDX = int'(COEF_HIGH_ADDR[c] - WORD_FIRST_ADDR);

    // Bit 16 joins the low word to form the 17-bit absolute value
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        coef_magnitude_reg[c] <= '0;
      end else begin
        coef_magnitude_reg[c] <= {words[HIGH_IDX][COEF_MSB_BIT[c]], words[LOW_IDX]};
      end
    end

    // Separate sign: one means the correction subtracts
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        coef_negative_reg[c] <= 1'b0;
      end else begin
        coef_negative_reg[c] <= words[HIGH_IDX][COEF_SIGN_BIT[c]];
      end
    end
  end

  // ==========================================================================
  // Offset ranges
  localparam int BO_IDX = int'(BRIDGE_OFFSET_ADDR - WORD_FIRST_ADDR);
  localparam int TO_IDX = int'(TEMP_OFFSET_ADDR - WORD_FIRST_ADDR);

  // Lower input range bound in sixteenths of full scale (negative side)
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bridge_range_sixteenths_reg <= RANGE_SIXTEENTHS;
      temp_range_sixteenths_reg   <= RANGE_SIXTEENTHS;
    end else begin
      bridge_range_sixteenths_reg <= RANGE_SIXTEENTHS -
                                     {1'b0, words[BO_IDX][RANGE_CODE_MSB:RANGE_CODE_LSB]};
      temp_range_sixteenths_reg   <= RANGE_SIXTEENTHS -
                                     {1'b0, words[TO_IDX][RANGE_CODE_MSB:RANGE_CODE_LSB]};
    end
  end

  // ==========================================================================
  // Low-calibration temperature and curve type
  localparam int SA_IDX = int'(SIGN_WORD_A_ADDR - WORD_FIRST_ADDR);
  localparam int LT_IDX = int'(LOW_CAL_TEMP_ADDR - WORD_FIRST_ADDR);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      low_cal_raw_temperature_reg <= WORD_RESET;
      low_cal_negative_reg        <= 1'b0;
      bridge_s_curve_reg          <= 1'b0;
    end else begin
      low_cal_raw_temperature_reg <= words[LT_IDX];
      low_cal_negative_reg        <= words[SA_IDX][LOW_CAL_SIGN_BIT];
      bridge_s_curve_reg          <= words[SA_IDX][BRIDGE_CURVE_BIT];
    end
  end

  // ==========================================================================
  // Measurement configuration decode
  localparam int MC_IDX = int'(MEAS_CONFIG_ADDR - WORD_FIRST_ADDR);

  logic [1:0] first_gain_code;
  logic [2:0] second_gain_code;
  logic [1:0] adc_width_code;
  logic [5:0] first_gain_next;
  logic [4:0] adc_bits_next;

  assign first_gain_code  = words[MC_IDX][FIRST_GAIN_MSB:FIRST_GAIN_LSB];
  assign second_gain_code = words[MC_IDX][SECOND_GAIN_MSB:SECOND_GAIN_LSB];
  assign adc_width_code   = words[MC_IDX][ADC_WIDTH_MSB:ADC_WIDTH_LSB];

  // First stage gain is a table, not a linear step
  always_comb begin
    case (first_gain_code)
      2'h0:    first_gain_next = FIRST_GAIN_0;
      2'h1:    first_gain_next = FIRST_GAIN_1;
      2'h2:    first_gain_next = FIRST_GAIN_2;
      2'h3:    first_gain_next = FIRST_GAIN_3;
      default: first_gain_next = FIRST_GAIN_0;
    endcase
  end

  // Coarse conversion width: two bits per code step
  always_comb begin
    case (adc_width_code)
      2'h0:    adc_bits_next = ADC_BITS_0;
      2'h1:    adc_bits_next = ADC_BITS_1;
      2'h2:    adc_bits_next = ADC_BITS_2;
      2'h3:    adc_bits_next = ADC_BITS_3;
      default: adc_bits_next = ADC_BITS_0;
    endcase
  end

  // Registered settings for the front amplifier and converter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      front_amplifier_first_gain_reg         <= FIRST_GAIN_0;
      front_amplifier_second_gain_tenths_reg <= SECOND_GAIN_BASE_TENTHS;
      gain_inverted_reg             <= 1'b0;
      coarse_adc_bits_reg           <= ADC_BITS_0;
    end else begin
      front_amplifier_first_gain_reg         <= first_gain_next;
      front_amplifier_second_gain_tenths_reg <= SECOND_GAIN_BASE_TENTHS + {2'b00, second_gain_code};
      gain_inverted_reg             <= words[MC_IDX][POLARITY_BIT];
      coarse_adc_bits_reg           <= adc_bits_next;
    end
  end

endmodule

// ### test/cal_store_properties.sv
// Concurrent checks on the store's word port and decoded outputs.
// Assumes it is bound into cal_coefficient_store; one clock, synchronous reset.
`timescale 1ns/10ps

module cal_store_properties (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  word_addr,
  input wire logic [15:0] word_wdata,
  input wire logic        word_wr,
  input wire logic        word_rd,
  input wire logic [15:0] word_rdata,
  input wire logic        word_rvalid_reg,
  input wire logic        write_refused_reg,
  input wire logic        config_changed_reg,
  input wire logic [cal_store_pkg::COEF_MAG_WIDTH-1:0] coef_magnitude_reg [cal_store_pkg::COEF_COUNT],
  input wire logic        coef_negative_reg [cal_store_pkg::COEF_COUNT],
  input wire logic [3:0]  bridge_range_sixteenths_reg,
  input wire logic [3:0]  temp_range_sixteenths_reg,
  input wire logic [15:0] low_cal_raw_temperature_reg,
  input wire logic [5:0]  front_amplifier_first_gain_reg,
  input wire logic [4:0]  front_amplifier_second_gain_tenths_reg,
  input wire logic        gain_inverted_reg,
  input wire logic [4:0]  coarse_adc_bits_reg
);
  import cal_store_pkg::*;
  localparam logic [5:0] G1 [4] = '{6'h0c, 6'h14, 6'h1e, 6'h28};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Write classification; offset words accept only whole 0x1000 steps
  wire logic off_wr  = word_wr && (word_addr == 8'h05 || word_addr == 8'h0c);
  wire logic bad     = word_wdata[15] || (word_wdata[11:0] != 12'h000);
  wire logic keep_wr = word_wr && (word_addr inside {[8'h03:8'h04], [8'h06:8'h0b], [8'h0d:8'h10]});

  // ==========================================================================
  // Assertions; decoded outputs move on the second edge after the write
  a_read_answer_pulse: assert property (word_rvalid_reg == $past(word_rd && rst_n))
    else $error("read answer pulse out of step");
  a_read_back_whole: assert property (keep_wr ##1 (word_rd && word_addr == $past(word_addr))
    |=> word_rdata == $past(word_wdata, 2)) else $error("word not read back whole");
  a_refused_offset_code: assert property (off_wr |=> write_refused_reg == $past(bad))
    else $error("offset code refusal wrong");
  a_refused_only_offset: assert property (!off_wr |=> !write_refused_reg)
    else $error("refusal without offset write");
  a_bridge_range_decode: assert property (off_wr && !bad && word_addr == 8'h05
    |=> ##1 bridge_range_sixteenths_reg == 4'h8 - $past(word_wdata[14:12], 2)) else $error("bridge range");
  a_temp_range_decode: assert property (off_wr && !bad && word_addr == 8'h0c
    |=> ##1 temp_range_sixteenths_reg == 4'h8 - $past(word_wdata[14:12], 2)) else $error("temp range");
  a_config_field_decode: assert property (word_wr && word_addr == 8'h10 |=> config_changed_reg ##1
    (front_amplifier_second_gain_tenths_reg == 5'h0b + {2'b00, $past(word_wdata[4:2], 2)}
    && gain_inverted_reg == $past(word_wdata[5], 2))) else $error("config fields");
  a_first_gain_decode: assert property (word_wr && word_addr == 8'h10
    |=> ##1 front_amplifier_first_gain_reg == G1[$past(word_wdata[1:0], 2)]) else $error("first gain");
  a_coef_low_join: assert property (word_wr && word_addr == 8'h06
    |=> ##1 coef_magnitude_reg[1][15:0] == $past(word_wdata, 2)) else $error("gain low word");
  a_sign_word_join: assert property (word_wr && word_addr == 8'h03 |=> ##1
    {coef_negative_reg[1], coef_magnitude_reg[1][16]} == $past(word_wdata[3:2], 2)) else $error("sign join");
  a_low_cal_word: assert property (word_wr && word_addr == 8'h0f
    |=> ##1 low_cal_raw_temperature_reg == $past(word_wdata, 2)) else $error("low cal word");
  a_adc_width_decode: assert property (word_wr && word_addr == 8'h10 |=> ##1
    coarse_adc_bits_reg == 5'h0a + {2'b00, $past(word_wdata[7:6], 2), 1'b0}) else $error("adc width");

  c_config_write: cover property (config_changed_reg);
  c_refused_write: cover property (write_refused_reg);
  c_write_then_read: cover property (keep_wr ##1 word_rd);
endmodule

bind cal_coefficient_store cal_store_properties u_cal_store_properties (
  .ref_clk(ref_clk), .rst_n(rst_n), .word_addr(word_addr), .word_wdata(word_wdata),
  .word_wr(word_wr), .word_rd(word_rd), .word_rdata(word_rdata), .word_rvalid_reg(word_rvalid_reg),
  .write_refused_reg(write_refused_reg), .config_changed_reg(config_changed_reg),
  .coef_magnitude_reg(coef_magnitude_reg), .coef_negative_reg(coef_negative_reg),
  .bridge_range_sixteenths_reg(bridge_range_sixteenths_reg),
  .temp_range_sixteenths_reg(temp_range_sixteenths_reg),
  .low_cal_raw_temperature_reg(low_cal_raw_temperature_reg),
  .front_amplifier_first_gain_reg(front_amplifier_first_gain_reg), .front_amplifier_second_gain_tenths_reg(front_amplifier_second_gain_tenths_reg),
  .gain_inverted_reg(gain_inverted_reg), .coarse_adc_bits_reg(coarse_adc_bits_reg));

// ### test/cal_host_model.sv
// Calibration host: sends whole words over the store's strobe port.
// Assumes tasks are called from the bench; every change lands on a rising edge.
`timescale 1ns/10ps

module cal_host_model (
  input  wire logic        ref_clk,
  output logic      [7:0]  word_addr,
  output logic      [15:0] word_wdata,
  output logic             word_wr,
  output logic             word_rd,
  input  wire logic [15:0] word_rdata,
  input  wire logic        word_rvalid_reg
);
  initial begin
    word_addr  = 8'h00;
    word_wdata = 16'h0000;
    word_wr    = 1'b0;
    word_rd    = 1'b0;
  end

  // ==========================================================================
  // Transfers; a write is taken at the edge that starts the next call
  task automatic write_word(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    word_addr  <= a;
    word_wdata <= d;
    word_wr    <= 1'b1;
    word_rd    <= 1'b0;
  endtask

  // Idle lines show the inverse, so a stale address or word never passes
  task automatic release_bus();
    @(posedge ref_clk);
    word_wr    <= 1'b0;
    word_rd    <= 1'b0;
    word_addr  <= ~word_addr;
    word_wdata <= ~word_wdata;
  endtask

  task automatic read_word(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge ref_clk);
    word_addr <= a;
    word_rd   <= 1'b1;
    word_wr   <= 1'b0;
    release_bus();
    // Answer is taken at the edge where the pulse is sampled high, before it drops
    @(posedge ref_clk);
    d = word_rdata;
    v = word_rvalid_reg;
  endtask
endmodule

// ### test/cal_coefficient_store_tb.sv
// Self-checking bench for the calibration coefficient store.
// Assumes the host model drives the word port and the checker is bound in.
`timescale 1ns/10ps

module cal_coefficient_store_tb;
  import cal_store_pkg::*;
  logic                      ref_clk;
  logic                      rst_n;
  logic [7:0]                word_addr;
  logic [15:0]               word_wdata;
  logic                      word_wr;
  logic                      word_rd;
  logic [15:0]               word_rdata;
  logic                      rvalid;
  logic [COEF_MAG_WIDTH-1:0] mag [COEF_COUNT];
  logic                      neg [COEF_COUNT];
  logic [3:0]                b_range;
  logic [3:0]                t_range;
  logic [15:0]               low_cal;
  logic                      s_curve;
  logic                      lc_neg;
  logic [5:0]                g1;
  logic [4:0]                g2;
  logic                      inv;
  logic [4:0]                adc;
  int                        fail_count;
  int                        num_checks;
  int                        mb [10] = '{0, 2, 4, 6, 8, 10, 12, 4, 0, 2};
  logic [15:0]               pat [2] = '{16'h2d36, 16'hd2c9};
  logic [5:0]                g1_exp [4] = '{6'h0c, 6'h14, 6'h1e, 6'h28};
  logic [15:0]               hi [2];
  logic [15:0]               lo [10];

  cal_coefficient_store u_cal_coefficient_store (.ref_clk(ref_clk), .rst_n(rst_n), .word_addr(word_addr),
    .word_wdata(word_wdata), .word_wr(word_wr), .word_rd(word_rd), .word_rdata(word_rdata),
    .word_rvalid_reg(rvalid), .write_refused_reg(), .config_changed_reg(), .coef_magnitude_reg(mag),
    .coef_negative_reg(neg), .bridge_range_sixteenths_reg(b_range), .temp_range_sixteenths_reg(t_range),
    .bridge_s_curve_reg(s_curve), .low_cal_raw_temperature_reg(low_cal), .low_cal_negative_reg(lc_neg),
    .front_amplifier_first_gain_reg(g1), .front_amplifier_second_gain_tenths_reg(g2), .gain_inverted_reg(inv),
    .coarse_adc_bits_reg(adc));
  cal_host_model u_cal_host_model (.ref_clk(ref_clk), .word_addr(word_addr), .word_wdata(word_wdata),
    .word_wr(word_wr), .word_rd(word_rd), .word_rdata(word_rdata), .word_rvalid_reg(rvalid));

  // ==========================================================================
  // Clock, watchdog and shared checks
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Run needs about 1300 cycles; a stuck port is cut off well beyond that
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    wrap_up();
  end
  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    u_cal_host_model.read_word(a, d, v);
    chk({16'h0000, v}, 17'h00001, "answer pulse");
    chk({1'b0, d}, {1'b0, exp}, "read word");
  endtask
  // Decoded outputs lag a write by two edges
  task automatic settle();
    u_cal_host_model.release_bus();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  initial begin
    fail_count = 0;
    num_checks = 0;
    rst_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 3; a <= 17; a++) rd_chk(8'(a), 16'h0000);
    chk({13'h0, b_range}, 17'h00008, "bridge range after reset");
    chk({11'h0, g1}, 17'h0000c, "first gain after reset");
    $display("test reset state done");
    // Both patterns together drive every sign and top bit both ways
    for (int p = 0; p < 2; p++) begin
      hi[0] = pat[p];
      hi[1] = ~pat[p];
      for (int i = 0; i < 10; i++) lo[i] = pat[p] ^ 16'(16'h1111 * i);
      lo[0] = p ? 16'h7000 : 16'h3000;
      lo[7] = p ? 16'h0000 : 16'h7000;
      u_cal_host_model.write_word(8'h03, hi[0]);
      u_cal_host_model.write_word(8'h04, hi[1]);
      for (int i = 0; i < 10; i++) u_cal_host_model.write_word(8'(5 + i), lo[i]);
      u_cal_host_model.write_word(8'h0f, ~pat[p]);
      settle();
      for (int i = 0; i < 10; i++) begin
        chk(mag[i], {hi[i / 7][mb[i]], lo[i]}, "magnitude");
        chk({16'h0, neg[i]}, {16'h0, hi[i / 7][mb[i] + 1]}, "sign");
        rd_chk(8'(5 + i), lo[i]);
      end
      chk({1'b0, low_cal}, {1'b0, ~pat[p]}, "low cal temperature");
      chk({16'h0, s_curve}, {16'h0, hi[0][14]}, "curve type");
      chk({16'h0, lc_neg}, {16'h0, hi[0][15]}, "low cal sign");
      chk({13'h0, t_range}, 17'(8 - lo[7][14:12]), "temp range");
      rd_chk(8'h03, hi[0]);
    end
    $display("test coefficient words done");
    // Every legal code, each chased two writes later by an illegal one
    for (int c = 0; c < 8; c++) begin
      u_cal_host_model.write_word(8'h05, {1'b0, 3'(c), 12'h000});
      u_cal_host_model.write_word(8'h0c, {1'b0, 3'(7 - c), 12'h000});
      u_cal_host_model.write_word(8'h05, c[0] ? 16'h8000 : 16'h0801);
      u_cal_host_model.write_word(8'h0c, 16'h7fff);
      settle();
      chk({13'h0, b_range}, 17'(8 - c), "bridge range");
      chk({13'h0, t_range}, 17'(1 + c), "temp range");
      rd_chk(8'h05, {1'b0, 3'(c), 12'h000});
    end
    $display("test offset codes done");
    for (int c = 0; c < 256; c++) begin
      u_cal_host_model.write_word(8'h10, {8'(255 - c), 8'(c)});
      settle();
      chk({11'h0, g1}, {11'h0, g1_exp[c % 4]}, "first gain");
      chk({12'h0, g2}, 17'(11 + (c / 4) % 8), "second gain");
      chk({16'h0, inv}, 17'((c / 32) % 2), "polarity");
      chk({12'h0, adc}, 17'(10 + 2 * (c / 64)), "adc bits");
    end
    rd_chk(8'h10, 16'h00ff);
    $display("test measurement config done");
    u_cal_host_model.write_word(8'h11, 16'hbeef);
    u_cal_host_model.write_word(8'h02, 16'hbeef);
    u_cal_host_model.write_word(8'h06, 16'ha5c3);
    rd_chk(8'h06, 16'ha5c3);
    rd_chk(8'h11, 16'h0000);
    rd_chk(8'h02, 16'h0000);
    $display("test unmapped and back to back done");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(8'h06, 16'h0000);
    rd_chk(8'h10, 16'h0000);
    $display("test second reset done");
    wrap_up();
  end
endmodule
